// file: logic/hfst_top.v
// health and fault status tree: fault words, persistency, alerts
`include "hfst_defs.vh"

// What this block does
// R1: health word carries faults in low byte, alerts in high byte.
// R2: fatal at bit 0, hardware/link/software errors bits 1-3, 4-7 reserved.
// R3: soft fault sets its category flag at once, fatal only after persisting.
// R4: master alert at bit 8 is OR of the four category alerts.
// R5: hardware, link, software, sensor alerts at bits 9-12, 13-15 reserved.
// R6: every alert bit has its own enable; only enabled bits propagate.
// R7: hardware error is OR of hardware word: supply bit 0, thermal bit 1.
// R8: supply fault is OR of nine out-of-bounds flags at bits 0-8.
// R9: thermal fault is OR of thermal word, board temperature at bit 0.
// R10: link error is OR of link word: port A bit 0, port B bit 1.
// R11: port A fault ORs tx, rx overrun, frame, break, parity bits 0-4.
// R12: port B fault uses the same five-flag layout as port A.
// R13: software error ORs software word: algorithm bit 0, data bit 1.
// R14: algorithm fault ORs init, saturation, deadline miss at bits 0-2.
// R15: supply, thermal and port faults are soft; algorithm faults are hard.
// R16: hard faults are fatal at once; soft ones need the high-pass counter.
// R17: fatal output pin mirrors fatal flag of the health word always.
// R18: category alert is OR of alert word ANDed with its mask.
// R19: four masks writable by field ids 0x0010 to 0x0013, any value.
// R20: reserved bits read zero and never feed any OR.
// R21: counter increment, decay and threshold are parameters.
module hfst_top #(
  parameter CNT_W = `HFST_CNT_W,
  parameter [CNT_W-1:0] CNT_INC = `HFST_CNT_INC,
  parameter [CNT_W-1:0] CNT_DEC = `HFST_CNT_DEC,
  parameter [CNT_W-1:0] CNT_THRESH = `HFST_CNT_THRESH,
  parameter DECAY_CYCLES = `HFST_DECAY_PERIOD_US * `HFST_CLK_MHZ
) (
  // clock and reset
  input wire core_clk_in,
  input wire nrst_in,
  // supply out-of-bounds flags
  input wire input_watts_oob_in,
  input wire input_amps_oob_in,
  input wire input_volts_oob_in,
  input wire rail_5v_oob_in,
  input wire rail_3v_oob_in,
  input wire rail_2v_oob_in,
  input wire ref_2v5_oob_in,
  input wire rail_6v_oob_in,
  input wire ground_ref_oob_in,
  // thermal flag
  input wire board_temp_oob_in,
  // serial port a flags
  input wire port_a_tx_overrun_in,
  input wire port_a_rx_overrun_in,
  input wire port_a_frame_fault_in,
  input wire port_a_line_break_seen_in,
  input wire port_a_parity_fault_in,
  // serial port b flags
  input wire port_b_tx_overrun_in,
  input wire port_b_rx_overrun_in,
  input wire port_b_frame_fault_in,
  input wire port_b_line_break_seen_in,
  input wire port_b_parity_fault_in,
  // algorithm flags
  input wire algo_init_fault_in,
  input wire sensor_saturation_in,
  input wire nav_deadline_miss_in,
  // summary of the data fault word
  input wire stored_data_fault_in,
  // alert words
  input wire [15:0] hw_alert_word_in,
  input wire [15:0] link_alert_word_in,
  input wire [15:0] sw_alert_word_in,
  input wire [15:0] sense_alert_word_in,
  // field write port
  input wire field_wr_in,
  input wire [15:0] field_wr_id_in,
  input wire [15:0] field_wr_data_in,
  // field read port
  input wire field_rd_in,
  input wire [15:0] field_rd_id_in,
  output reg field_rd_valid_out,
  output reg field_rd_hit_out,
  output reg [15:0] field_rd_data_out,
  // status words
  output reg [15:0] global_health_word_out,
  output reg [15:0] hw_fault_word_out,
  output reg [15:0] supply_fault_word_out,
  output reg [15:0] thermal_fault_word_out,
  output reg [15:0] link_fault_word_out,
  output reg [15:0] port_a_fault_word_out,
  output reg [15:0] port_b_fault_word_out,
  output reg [15:0] sw_fault_word_out,
  output reg [15:0] algo_fault_word_out,
  // alert masks as stored
  output reg [15:0] hw_alert_mask_out,
  output reg [15:0] link_alert_mask_out,
  output reg [15:0] sw_alert_mask_out,
  output reg [15:0] sense_alert_mask_out,
  // fatal failure pin
  output reg fatal_pin_out
);

  localparam DIV_W = 32;
  localparam [DIV_W-1:0] DIV_LAST = DECAY_CYCLES - 1;

  reg [15:0] supply_d;
  reg [15:0] thermal_d;
  reg [15:0] port_a_d;
  reg [15:0] port_b_d;
  reg [15:0] algo_d;
  reg [15:0] hw_d;
  reg [15:0] link_d;
  reg [15:0] sw_d;
  reg [15:0] global_d;
  reg supply_fault_flag;
  reg thermal_fault_flag;
  reg port_a_fault;
  reg port_b_fault;
  reg algo_fault_flag;
  reg hw_fault_flag;
  reg link_fault_flag;
  reg sw_fault_flag;
  reg hard_fault;
  reg fatal_flag;
  reg master_alert_flag;
  reg [DIV_W-1:0] div_q;
  reg decay_tick_q;
  wire [`HFST_N_SOFT-1:0] soft_src;
  wire [`HFST_N_SOFT-1:0] soft_trip;
  wire [`HFST_N_ALERT-1:0] alert_flag;
  wire hw_alert_flag;
  wire link_alert_flag;
  wire sw_alert_flag;
  wire sense_alert_flag;

  // leaf words, reserved bits forced zero
  always @* begin
    supply_d = `HFST_ZERO_WORD;
    thermal_d = `HFST_ZERO_WORD;
    port_a_d = `HFST_ZERO_WORD;
    port_b_d = `HFST_ZERO_WORD;
    algo_d = `HFST_ZERO_WORD;
    // R8: supply out-of-bounds bits
    supply_d[`HFST_SUPPLY_BITS-1:0] = {ground_ref_oob_in, rail_6v_oob_in,
      ref_2v5_oob_in, rail_2v_oob_in, rail_3v_oob_in, rail_5v_oob_in,
      input_volts_oob_in, input_amps_oob_in, input_watts_oob_in};
    // R9: board temperature bit
    thermal_d[`HFST_TH_BOARD] = board_temp_oob_in;
    // R11: port a error bits
    port_a_d[`HFST_PORT_BITS-1:0] = {port_a_parity_fault_in,
      port_a_line_break_seen_in, port_a_frame_fault_in,
      port_a_rx_overrun_in, port_a_tx_overrun_in};
    // R12: port b same layout
    port_b_d[`HFST_PORT_BITS-1:0] = {port_b_parity_fault_in,
      port_b_line_break_seen_in, port_b_frame_fault_in,
      port_b_rx_overrun_in, port_b_tx_overrun_in};
    // R14: algorithm fault bits
    algo_d[`HFST_ALGO_BITS-1:0] = {nav_deadline_miss_in,
      sensor_saturation_in, algo_init_fault_in};
  end

  // intermediate words and reductions
  always @* begin
    hw_d = `HFST_ZERO_WORD;
    link_d = `HFST_ZERO_WORD;
    sw_d = `HFST_ZERO_WORD;
    // R20: reductions over used bits only
    supply_fault_flag = |supply_d[`HFST_SUPPLY_BITS-1:0];
    thermal_fault_flag = thermal_d[`HFST_TH_BOARD];
    port_a_fault = |port_a_d[`HFST_PORT_BITS-1:0];
    port_b_fault = |port_b_d[`HFST_PORT_BITS-1:0];
    algo_fault_flag = |algo_d[`HFST_ALGO_BITS-1:0];
    // R7: hardware word fields
    hw_d[`HFST_HW_SUPPLY] = supply_fault_flag;
    hw_d[`HFST_HW_THERMAL] = thermal_fault_flag;
    // R10: link word fields
    link_d[`HFST_LK_PORT_A] = port_a_fault;
    link_d[`HFST_LK_PORT_B] = port_b_fault;
    // R13: software word fields
    sw_d[`HFST_SW_ALGO] = algo_fault_flag;
    sw_d[`HFST_SW_DATA] = stored_data_fault_in;
    // R3: category flags follow instantly
    hw_fault_flag = hw_d[`HFST_HW_SUPPLY] | hw_d[`HFST_HW_THERMAL];
    link_fault_flag = link_d[`HFST_LK_PORT_A] | link_d[`HFST_LK_PORT_B];
    sw_fault_flag = sw_d[`HFST_SW_ALGO] | sw_d[`HFST_SW_DATA];
  end

  // R15: soft sources feed persistency counters
  assign soft_src = {port_b_fault, port_a_fault, thermal_fault_flag,
    supply_fault_flag};

  // decay tick divider
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q <= {DIV_W{1'b0}};
      decay_tick_q <= 1'b0;
    end else if (div_q == DIV_LAST) begin
      div_q <= {DIV_W{1'b0}};
      decay_tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      decay_tick_q <= 1'b0;
    end
  end

  // R21: one counter per soft source
  genvar s;
  generate
    for (s = 0; s < `HFST_N_SOFT; s = s + 1) begin : g_soft
      hfst_persist #(
        .CW(CNT_W),
        .INC(CNT_INC),
        .DEC(CNT_DEC),
        .THRESH(CNT_THRESH)
      ) u_persist (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .decay_tick_in(decay_tick_q),
        .fault_in(soft_src[s]),
        .trip_out(soft_trip[s])
      );
    end
  endgenerate

  // R6: masked alert reduction
  hfst_alert #(
    .N(`HFST_N_ALERT)
  ) u_alert (
    .word_in({sense_alert_word_in, sw_alert_word_in, link_alert_word_in,
      hw_alert_word_in}),
    .mask_in({sense_alert_mask_out, sw_alert_mask_out, link_alert_mask_out,
      hw_alert_mask_out}),
    .flag_out(alert_flag)
  );

  assign hw_alert_flag = alert_flag[0];
  assign link_alert_flag = alert_flag[1];
  assign sw_alert_flag = alert_flag[2];
  assign sense_alert_flag = alert_flag[3];

  // fatal decision and global word assembly
  always @* begin
    // R16: hard faults are fatal at once
    hard_fault = algo_fault_flag | stored_data_fault_in;
    fatal_flag = hard_fault | (|soft_trip);
    // R4: master alert is or of categories
    master_alert_flag = hw_alert_flag | link_alert_flag | sw_alert_flag |
      sense_alert_flag;
    global_d = `HFST_ZERO_WORD;
    // R1: fault byte low
    // R2: fatal and error bit places
    global_d[`HFST_G_FATAL] = fatal_flag;
    global_d[`HFST_G_HW_FLT] = hw_fault_flag;
    global_d[`HFST_G_LINK_FLT] = link_fault_flag;
    global_d[`HFST_G_SW_FLT] = sw_fault_flag;
    // R5: alert bit places in high byte
    global_d[`HFST_G_MASTER_ALR] = master_alert_flag;
    global_d[`HFST_G_HW_ALR] = hw_alert_flag;
    global_d[`HFST_G_LINK_ALR] = link_alert_flag;
    global_d[`HFST_G_SW_ALR] = sw_alert_flag;
    global_d[`HFST_G_SENSE_ALR] = sense_alert_flag;
  end

  // registered status words and fatal pin
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      global_health_word_out <= `HFST_ZERO_WORD;
      hw_fault_word_out <= `HFST_ZERO_WORD;
      supply_fault_word_out <= `HFST_ZERO_WORD;
      thermal_fault_word_out <= `HFST_ZERO_WORD;
      link_fault_word_out <= `HFST_ZERO_WORD;
      port_a_fault_word_out <= `HFST_ZERO_WORD;
      port_b_fault_word_out <= `HFST_ZERO_WORD;
      sw_fault_word_out <= `HFST_ZERO_WORD;
      algo_fault_word_out <= `HFST_ZERO_WORD;
      fatal_pin_out <= 1'b0;
    end else begin
      global_health_word_out <= global_d;
      hw_fault_word_out <= hw_d;
      supply_fault_word_out <= supply_d;
      thermal_fault_word_out <= thermal_d;
      link_fault_word_out <= link_d;
      port_a_fault_word_out <= port_a_d;
      port_b_fault_word_out <= port_b_d;
      sw_fault_word_out <= sw_d;
      algo_fault_word_out <= algo_d;
      // R17: pin loads same value as bit 0
      fatal_pin_out <= global_d[`HFST_G_FATAL];
    end
  end

  // R19: mask writes by field id
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hw_alert_mask_out <= `HFST_MASK_RST;
      link_alert_mask_out <= `HFST_MASK_RST;
      sw_alert_mask_out <= `HFST_MASK_RST;
      sense_alert_mask_out <= `HFST_MASK_RST;
    end else if (field_wr_in) begin
      case (field_wr_id_in)
        `HFST_ID_HW_MASK: begin
          hw_alert_mask_out <= field_wr_data_in;
        end
        `HFST_ID_LINK_MASK: begin
          link_alert_mask_out <= field_wr_data_in;
        end
        `HFST_ID_SW_MASK: begin
          sw_alert_mask_out <= field_wr_data_in;
        end
        `HFST_ID_SENSE_MASK: begin
          sense_alert_mask_out <= field_wr_data_in;
        end
        default: begin
          hw_alert_mask_out <= hw_alert_mask_out;
        end
      endcase
    end
  end

  // field read: one cycle answer, miss reads zero
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      field_rd_valid_out <= 1'b0;
      field_rd_hit_out <= 1'b0;
      field_rd_data_out <= `HFST_ZERO_WORD;
    end else begin
      field_rd_valid_out <= field_rd_in;
      field_rd_hit_out <= 1'b0;
      field_rd_data_out <= `HFST_ZERO_WORD;
      if (field_rd_in) begin
        field_rd_hit_out <= 1'b1;
        case (field_rd_id_in)
          `HFST_ID_GLOBAL: begin
            field_rd_data_out <= global_health_word_out;
          end
          `HFST_ID_HW: begin
            field_rd_data_out <= hw_fault_word_out;
          end
          `HFST_ID_SUPPLY: begin
            field_rd_data_out <= supply_fault_word_out;
          end
          `HFST_ID_THERMAL: begin
            field_rd_data_out <= thermal_fault_word_out;
          end
          `HFST_ID_LINK: begin
            field_rd_data_out <= link_fault_word_out;
          end
          `HFST_ID_PORT_A: begin
            field_rd_data_out <= port_a_fault_word_out;
          end
          `HFST_ID_PORT_B: begin
            field_rd_data_out <= port_b_fault_word_out;
          end
          `HFST_ID_SW: begin
            field_rd_data_out <= sw_fault_word_out;
          end
          `HFST_ID_ALGO: begin
            field_rd_data_out <= algo_fault_word_out;
          end
          `HFST_ID_HW_MASK: begin
            field_rd_data_out <= hw_alert_mask_out;
          end
          `HFST_ID_LINK_MASK: begin
            field_rd_data_out <= link_alert_mask_out;
          end
          `HFST_ID_SW_MASK: begin
            field_rd_data_out <= sw_alert_mask_out;
          end
          `HFST_ID_SENSE_MASK: begin
            field_rd_data_out <= sense_alert_mask_out;
          end
          default: begin
            field_rd_hit_out <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // hfst_top

// file: logic/hfst_defs.vh
// shared constants for the health and fault status tree
`ifndef HFST_DEFS_VH
`define HFST_DEFS_VH

// word width of every status field
`define HFST_W 16

// global health word layout, fault byte low, alert byte high
`define HFST_G_FATAL 0
`define HFST_G_HW_FLT 1
`define HFST_G_LINK_FLT 2
`define HFST_G_SW_FLT 3
`define HFST_G_MASTER_ALR 8
`define HFST_G_HW_ALR 9
`define HFST_G_LINK_ALR 10
`define HFST_G_SW_ALR 11
`define HFST_G_SENSE_ALR 12

// hardware fault word
`define HFST_HW_SUPPLY 0
`define HFST_HW_THERMAL 1

// supply fault word: nine used bits
`define HFST_SUPPLY_BITS 9

// thermal fault word
`define HFST_TH_BOARD 0

// link fault word
`define HFST_LK_PORT_A 0
`define HFST_LK_PORT_B 1

// serial port word: five used bits
`define HFST_PORT_BITS 5

// software fault word
`define HFST_SW_ALGO 0
`define HFST_SW_DATA 1

// algorithm fault word: three used bits
`define HFST_ALGO_BITS 3

// soft persistency sources: supply, thermal, port a, port b
`define HFST_N_SOFT 4
`define HFST_N_ALERT 4

// configuration field ids of the alert masks
`define HFST_ID_HW_MASK 16'h0010
`define HFST_ID_LINK_MASK 16'h0011
`define HFST_ID_SW_MASK 16'h0012
`define HFST_ID_SENSE_MASK 16'h0013

// read ids of the status words
`define HFST_ID_GLOBAL 16'h0100
`define HFST_ID_HW 16'h0101
`define HFST_ID_SUPPLY 16'h0102
`define HFST_ID_THERMAL 16'h0103
`define HFST_ID_LINK 16'h0104
`define HFST_ID_PORT_A 16'h0105
`define HFST_ID_PORT_B 16'h0106
`define HFST_ID_SW 16'h0107
`define HFST_ID_ALGO 16'h0108

// reset values
`define HFST_ZERO_WORD 16'h0000
`define HFST_MASK_RST 16'h0000

// clock rate and soft fault decay period
`define HFST_CLK_MHZ 125
`define HFST_DECAY_PERIOD_US 1000

// persistency counter defaults
`define HFST_CNT_W 8
`define HFST_CNT_INC 8'h04
`define HFST_CNT_DEC 8'h01
`define HFST_CNT_THRESH 8'h10

`endif

// file: logic/hfst_persist.v
// high-pass persistency counter for one soft fault source
module hfst_persist #(
  parameter CW = 8,
  parameter [CW-1:0] INC = 8'h04,
  parameter [CW-1:0] DEC = 8'h01,
  parameter [CW-1:0] THRESH = 8'h10
) (
  // clock and reset
  input wire core_clk_in,
  input wire nrst_in,
  // decay pulse and fault level
  input wire decay_tick_in,
  input wire fault_in,
  // sticky trip
  output wire trip_out
);

  reg [CW-1:0] cnt_q;
  reg [CW-1:0] cnt_d;
  reg trip_q;
  wire [CW:0] sum;

  assign sum = {1'b0, cnt_q} + {1'b0, INC};
  assign trip_out = trip_q;

  // R16: climb on fault, decay on tick
  always @* begin
    cnt_d = cnt_q;
    if (fault_in) begin
      cnt_d = sum[CW] ? {CW{1'b1}} : sum[CW-1:0];
    end else if (decay_tick_in) begin
      cnt_d = (cnt_q > DEC) ? cnt_q - DEC : {CW{1'b0}};
    end
  end

  // R3: trip once threshold reached
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= {CW{1'b0}};
      trip_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      trip_q <= trip_q | (cnt_d >= THRESH);
    end
  end

endmodule // hfst_persist

// file: logic/hfst_alert.v
// masked alert reduction for all alert categories
`include "hfst_defs.vh"
module hfst_alert #(
  parameter N = 4
) (
  // alert words and masks, category k in slice k
  input wire [N*16-1:0] word_in,
  input wire [N*16-1:0] mask_in,
  // per-category flags
  output wire [N-1:0] flag_out
);

  genvar k;
  generate
    for (k = 0; k < N; k = k + 1) begin : g_cat
      // R18: or of word and mask
      assign flag_out[k] = |(word_in[k*16 +: 16] & mask_in[k*16 +: 16]);
    end
  endgenerate

endmodule // hfst_alert

// file: verif/hfst_top_sva.sv
// concurrent assertions on the ports of the health and fault status tree
module hfst_top_sva (
  // clock and reset
  input wire core_clk_in,
  input wire nrst_in,
  // mask write port
  input wire field_wr_in,
  input wire [15:0] field_wr_id_in,
  input wire [15:0] field_wr_data_in,
  // alert words and stored masks
  input wire [15:0] hw_alert_word_in,
  input wire [15:0] link_alert_word_in,
  input wire [15:0] sw_alert_word_in,
  input wire [15:0] sense_alert_word_in,
  input wire [15:0] hw_alert_mask_out,
  input wire [15:0] link_alert_mask_out,
  input wire [15:0] sw_alert_mask_out,
  input wire [15:0] sense_alert_mask_out,
  // status words and fatal pin
  input wire [15:0] global_health_word_out,
  input wire [15:0] hw_fault_word_out,
  input wire [15:0] supply_fault_word_out,
  input wire [15:0] thermal_fault_word_out,
  input wire [15:0] link_fault_word_out,
  input wire [15:0] port_a_fault_word_out,
  input wire [15:0] port_b_fault_word_out,
  input wire [15:0] sw_fault_word_out,
  input wire [15:0] algo_fault_word_out,
  input wire fatal_pin_out
);
  // health word alias, soft category summary, masked alert summary
  wire [15:0] gw = global_health_word_out;
  wire soft_w = |gw[2:1];
  wire [3:0] alr_w = {|(sense_alert_word_in & sense_alert_mask_out),
    |(sw_alert_word_in & sw_alert_mask_out), |(link_alert_word_in & link_alert_mask_out),
    |(hw_alert_word_in & hw_alert_mask_out)};
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);
  fatal_pin_a: assert property (fatal_pin_out == gw[0])
    else $error("fatal pin differs from health word");
  resv_zero_a: assert property ({gw[7:4], gw[15:13], hw_fault_word_out[15:2],
    supply_fault_word_out[15:9], thermal_fault_word_out[15:1], link_fault_word_out[15:2],
    port_a_fault_word_out[15:5], port_b_fault_word_out[15:5], sw_fault_word_out[15:2],
    algo_fault_word_out[15:3]} == 0) else $error("reserved bit set");
  master_or_a: assert property (gw[8] == |gw[12:9])
    else $error("master alert wrong");
  cat_or_a: assert property (gw[3:1] == {|sw_fault_word_out,
    |link_fault_word_out, |hw_fault_word_out}) else $error("category error wrong");
  leaf_or_a: assert property ({hw_fault_word_out[1:0], link_fault_word_out[1:0],
    sw_fault_word_out[0]} == {|thermal_fault_word_out, |supply_fault_word_out,
    |port_b_fault_word_out, |port_a_fault_word_out, |algo_fault_word_out})
    else $error("leaf reduction wrong");
  hard_fatal_a: assert property ((|algo_fault_word_out || sw_fault_word_out[1]) |-> gw[0])
    else $error("hard fault without fatal");
  alert_mask_a: assert property ($past(nrst_in) |-> gw[12:9] == $past(alr_w))
    else $error("category alert wrong");
  mask_load_a: assert property (field_wr_in && field_wr_id_in == 16'h0010 |=>
    hw_alert_mask_out == $past(field_wr_data_in)) else $error("mask not loaded");
  soft_defer_a: assert property ($rose(soft_w) && !gw[3] && !$past(gw[0]) |-> !gw[0])
    else $error("soft fault fatal at once");
  soft_trip_a: assert property ($rose(gw[0]) && !gw[3] |-> $past(soft_w))
    else $error("fatal without soft cause");
  // main scenarios reached
  trip_c: cover property ($rose(gw[0]) && !gw[3]);
  alert_c: cover property (gw[8]);
  hard_c: cover property (gw[3] && fatal_pin_out);
endmodule // hfst_top_sva

bind hfst_top hfst_top_sva chk_u (
  .core_clk_in, .nrst_in, .field_wr_in, .field_wr_id_in, .field_wr_data_in,
  .hw_alert_word_in, .link_alert_word_in, .sw_alert_word_in, .sense_alert_word_in,
  .hw_alert_mask_out, .link_alert_mask_out, .sw_alert_mask_out, .sense_alert_mask_out,
  .global_health_word_out, .hw_fault_word_out, .supply_fault_word_out,
  .thermal_fault_word_out, .link_fault_word_out, .port_a_fault_word_out,
  .port_b_fault_word_out, .sw_fault_word_out, .algo_fault_word_out, .fatal_pin_out
);

// file: verif/hfst_tb_top.sv
// self-checking testbench for the health and fault status tree
module hfst_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus, observed outputs and counters
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [23:0] flt = 24'h00_0000;
  logic [15:0] aw [4] = '{4{16'h0000}};
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wr_id = 16'h0000;
  logic [15:0] wr_dat = 16'h0000;
  logic [15:0] rd_id = 16'h0000;
  logic rd_v, rd_hit, fpin;
  logic [15:0] rd_dat;
  logic [15:0] wd [9];
  logic [15:0] mk [4];
  int n_fail = 0;
  int n_checks = 0;

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  // design with a short decay period
  hfst_top #(.DECAY_CYCLES(8)) dut_u (
    .core_clk_in(core_clk), .nrst_in(nrst),
    .input_watts_oob_in(flt[0]), .input_amps_oob_in(flt[1]), .input_volts_oob_in(flt[2]),
    .rail_5v_oob_in(flt[3]), .rail_3v_oob_in(flt[4]), .rail_2v_oob_in(flt[5]),
    .ref_2v5_oob_in(flt[6]), .rail_6v_oob_in(flt[7]), .ground_ref_oob_in(flt[8]),
    .board_temp_oob_in(flt[9]), .port_a_tx_overrun_in(flt[10]),
    .port_a_rx_overrun_in(flt[11]), .port_a_frame_fault_in(flt[12]),
    .port_a_line_break_seen_in(flt[13]), .port_a_parity_fault_in(flt[14]),
    .port_b_tx_overrun_in(flt[15]), .port_b_rx_overrun_in(flt[16]),
    .port_b_frame_fault_in(flt[17]), .port_b_line_break_seen_in(flt[18]),
    .port_b_parity_fault_in(flt[19]), .algo_init_fault_in(flt[20]),
    .sensor_saturation_in(flt[21]), .nav_deadline_miss_in(flt[22]),
    .stored_data_fault_in(flt[23]), .hw_alert_word_in(aw[0]), .link_alert_word_in(aw[1]),
    .sw_alert_word_in(aw[2]), .sense_alert_word_in(aw[3]),
    .field_wr_in(wr), .field_wr_id_in(wr_id), .field_wr_data_in(wr_dat),
    .field_rd_in(rd), .field_rd_id_in(rd_id), .field_rd_valid_out(rd_v),
    .field_rd_hit_out(rd_hit), .field_rd_data_out(rd_dat),
    .global_health_word_out(wd[0]), .hw_fault_word_out(wd[1]),
    .supply_fault_word_out(wd[2]), .thermal_fault_word_out(wd[3]),
    .link_fault_word_out(wd[4]), .port_a_fault_word_out(wd[5]),
    .port_b_fault_word_out(wd[6]), .sw_fault_word_out(wd[7]),
    .algo_fault_word_out(wd[8]), .hw_alert_mask_out(mk[0]), .link_alert_mask_out(mk[1]),
    .sw_alert_mask_out(mk[2]), .sense_alert_mask_out(mk[3]), .fatal_pin_out(fpin)
  );

  // advance n edges, then land 1 ns after the last
  task automatic step(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // word comparison
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // reset held for n edges
  task automatic do_reset(input int n);
    nrst = 1'b0;
    step(n);
    nrst = 1'b1;
  endtask

  // one field write
  task automatic wr_field(input logic [15:0] id, input logic [15:0] dat);
    wr_id = id;
    wr_dat = dat;
    wr = 1'b1;
    step();
    wr = 1'b0;
    step();
  endtask

  // one field read, answer valid exactly one cycle
  task automatic rd_chk(input logic [15:0] id, input logic [15:0] exp, input logic hit);
    rd_id = id;
    rd = 1'b1;
    step();
    rd = 1'b0;
    chk16({14'h0000, rd_v, rd_hit}, {14'h0000, 1'b1, hit}, "read flags");
    chk16(rd_dat, exp, "read data");
    step();
    chk16({15'h0000, rd_v}, 16'h0000, "valid width");
  endtask

  // one leaf at a time, checked through every level
  task automatic t_leaf();
    logic [15:0] e [9];
    for (int i = 0; i < 24; i++) begin
      do_reset(2);
      flt = 24'h00_0001 << i;
      step();
      e[2] = (i < 9) ? 16'h0001 << i : 16'h0000;
      e[3] = {15'h0000, i == 9};
      e[5] = (i >= 10 && i < 15) ? 16'h0001 << (i - 10) : 16'h0000;
      e[6] = (i >= 15 && i < 20) ? 16'h0001 << (i - 15) : 16'h0000;
      e[8] = (i >= 20 && i < 23) ? 16'h0001 << (i - 20) : 16'h0000;
      e[1] = {14'h0000, e[3] != 0, e[2] != 0};
      e[4] = {14'h0000, e[6] != 0, e[5] != 0};
      e[7] = {14'h0000, i == 23, e[8] != 0};
      e[0] = {12'h000, e[7] != 0, e[4] != 0, e[1] != 0, i >= 20};
      for (int j = 0; j < 9; j++) chk16(wd[j], e[j], "leaf word");
      chk16({15'h0000, fpin}, {15'h0000, i >= 20}, "fatal pin");
      flt = 24'h00_0000;
      step();
      chk16(wd[0], 16'h0000, "fatal follows input");
    end
    $display("leaf test done");
  endtask

  // soft sources: three cycles never trip, decay bleeds, four cycles trip
  task automatic t_persist();
    int src [4] = '{3, 9, 12, 17};
    for (int k = 0; k < 4; k++) begin
      do_reset(2);
      flt = 24'h00_0001 << src[k];
      step(3);
      flt = 24'h00_0000;
      step(20);
      flt = 24'h00_0001 << src[k];
      step();
      flt = 24'h00_0000;
      step(3);
      chk16(wd[0], 16'h0000, "decayed no trip");
      do_reset(2);
      flt = 24'h00_0001 << src[k];
      step(4);
      flt = 24'h00_0000;
      chk16(wd[0], (src[k] < 10) ? 16'h0002 : 16'h0004, "category before trip");
      step();
      chk16(wd[0], 16'h0001, "soft trip");
      step(20);
      chk16({15'h0000, fpin}, 16'h0001, "trip held");
    end
    $display("persistency test done");
  endtask

  // masks: unmapped id ignored, each mask gates its own category
  task automatic t_alert();
    logic [15:0] m [4] = '{16'h0001, 16'h0002, 16'h0004, 16'h8000};
    logic [15:0] pre;
    do_reset(2);
    wr_field(16'h0014, 16'hFFFF);
    for (int k = 0; k < 4; k++) chk16(mk[k], 16'h0000, "mask untouched");
    for (int k = 0; k < 4; k++) wr_field(16'h0010 + 16'(k), m[k]);
    for (int k = 0; k < 4; k++) begin
      chk16(mk[k], m[k], "mask stored");
      rd_chk(16'h0010 + 16'(k), m[k], 1'b1);
      // earlier categories keep their enabled alert standing
      pre = (16'h0200 << k) - 16'h0200;
      aw[k] = ~m[k];
      step();
      chk16(wd[0], (k == 0) ? 16'h0000 : (16'h0100 | pre), "masked alert");
      aw[k] = m[k];
      step();
      chk16(wd[0], 16'h0100 | pre | (16'h0200 << k), "enabled alert");
    end
    step();
    chk16(wd[0], 16'h1F00, "all alerts");
    aw = '{4{16'h0000}};
    $display("alert test done");
  endtask

  // every word through the read port, unknown ids refused
  task automatic t_read();
    logic [15:0] e [9] = '{16'h000F, 16'h0001, 16'h0001, 16'h0000, 16'h0002,
      16'h0000, 16'h0010, 16'h0003, 16'h0004};
    do_reset(2);
    aw[3] = 16'h8000;
    flt = 24'hC8_0001;
    step(2);
    for (int j = 0; j < 9; j++) rd_chk(16'h0100 + 16'(j), e[j], 1'b1);
    rd_chk(16'h0109, 16'h0000, 1'b0);
    rd_chk(16'h0014, 16'h0000, 1'b0);
    flt = 24'h00_0000;
    aw[3] = 16'h0000;
    step();
    chk16(wd[0], 16'h0001, "soft trip sticky");
    $display("read test done");
  endtask

  // counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    do_reset(16);
    for (int j = 0; j < 9; j++) chk16(wd[j], 16'h0000, "reset word");
    t_leaf();
    t_persist();
    t_alert();
    t_read();
    stop_test();
  end

  // watchdog: the tests need under 2000 cycles
  initial begin
    #(8 * 20000);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // hfst_tb_top
